// *** core/irq_ctrl_pkg.sv ***
/*
  Constants, bit positions and carrier types for the interrupt controller
  of the reader frontend. Assumes one 100 MHz system clock.
*/
package irq_ctrl_pkg;
  // ----------------------------------------------------------------
  // register layout
  // ----------------------------------------------------------------
  localparam int          REG_W          = 8;
  localparam int          MODE_BIT       = 7;
  localparam logic [7:0]  FLAGS_RST      = 8'h00;
  localparam logic [7:0]  ENABLE_RST     = 8'h00;
  // low register bits
  localparam int          TX_DONE_BIT    = 0;
  localparam int          RX_DONE_BIT    = 1;
  localparam int          IDLE_BIT       = 2;
  localparam int          FIFO_HIGH_BIT  = 3;
  localparam int          FIFO_LOW_BIT   = 4;
  localparam int          RX_ERROR_BIT   = 5;
  localparam int          CARD_BIT       = 6;
  localparam int          SOF_BIT        = 7;
  // high register bits
  localparam int          TIMER_BASE_BIT = 0;
  localparam int          TIMER_COUNT    = 4;
  localparam int          ANY_EVENT_BIT  = 6;
  localparam logic [7:0]  HIGH_SRC_MASK  = 8'h0F;

  typedef enum logic [1:0] {
    TX_OTHER,
    TX_PAYLOAD,
    TX_END_FRAME
  } tx_state_t;

  typedef struct packed {
    logic       wr_en;
    logic [7:0] data;
  } reg_write_t;

  typedef struct packed {
    reg_write_t flags_low;
    reg_write_t flags_high;
    reg_write_t enable_low;
    reg_write_t enable_high;
  } host_writes_t;
endpackage

// *** core/irq_ctrl.sv ***
/*
  Interrupt controller: sticky event flags, enables, global flag,
  status bit and request pin. Assumes event inputs synchronous to clk.
*/
`timescale 1ns/1ps
module irq_ctrl #(
  parameter int FIFO_DEPTH = 512,
  parameter int LEVEL_W    = 9
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  // host register writes
  input  wire irq_ctrl_pkg::host_writes_t  host_wr,
  // configuration
  input  wire logic                        irq_pin_enable,
  input  wire logic                        card_detect_mode,
  input  wire logic [LEVEL_W-2:0]          fifo_threshold,
  input  wire logic                        fifo_threshold_extension,
  // event sources
  input  wire logic [3:0]                  timer_underflow,
  input  wire irq_ctrl_pkg::tx_state_t     tx_state,
  input  wire logic                        rx_stream_end,
  input  wire logic                        command_is_idle,
  input  wire logic [LEVEL_W:0]            fifo_fill,
  input  wire logic [7:0]                  uart_error,
  input  wire logic                        card_detected,
  input  wire logic                        receiving,
  input  wire logic                        sof_detected,
  input  wire logic                        subcarrier_detected,
  // register views and outputs
  output logic [7:0]                       event_flags_low,
  output logic [7:0]                       event_flags_high,
  output logic [7:0]                       event_enable_low,
  output logic [7:0]                       event_enable_high,
  output logic                             status_irq,
  output logic                             irq_out
);
  if (FIFO_DEPTH > (1 << LEVEL_W) || LEVEL_W < 2) begin : g_bad_size
    $error("fifo depth does not fit level width");
  end

  // ----------------------------------------------------------------
  // set/clear write decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] apply_write(input logic [7:0] cur, input irq_ctrl_pkg::reg_write_t w);
    logic [7:0] m;
    m = {1'b0, w.data[6:0]};
    if (!w.wr_en)
      apply_write = cur;
    else if (w.data[irq_ctrl_pkg::MODE_BIT])
      apply_write = cur | m;
    else
      apply_write = cur & ~m;
  endfunction

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  logic                  idle_prev_reg;
  logic                  hi_prev_reg;
  logic                  lo_prev_reg;
  irq_ctrl_pkg::tx_state_t tx_prev_reg;
  wire  [LEVEL_W:0]      thr_full  = {1'b0, fifo_threshold_extension, fifo_threshold};
  wire  [LEVEL_W:0]      depth_w   = (LEVEL_W+1)'(FIFO_DEPTH);
  wire                   fifo_high_status = (depth_w - fifo_fill) <= thr_full;
  wire                   fifo_low_status  = fifo_fill <= {2'b00, fifo_threshold};

  wire [7:0] hw_low;
  assign hw_low[irq_ctrl_pkg::TX_DONE_BIT]   = (tx_prev_reg == irq_ctrl_pkg::TX_PAYLOAD) &&
                                               (tx_state == irq_ctrl_pkg::TX_END_FRAME);
  assign hw_low[irq_ctrl_pkg::RX_DONE_BIT]   = rx_stream_end;
  assign hw_low[irq_ctrl_pkg::IDLE_BIT]      = command_is_idle && !idle_prev_reg;
  assign hw_low[irq_ctrl_pkg::FIFO_HIGH_BIT] = fifo_high_status && !hi_prev_reg;
  assign hw_low[irq_ctrl_pkg::FIFO_LOW_BIT]  = fifo_low_status && !lo_prev_reg;
  assign hw_low[irq_ctrl_pkg::RX_ERROR_BIT]  = |uart_error;
  assign hw_low[irq_ctrl_pkg::CARD_BIT]      = card_detected && card_detect_mode;
  assign hw_low[irq_ctrl_pkg::SOF_BIT]       = receiving && (sof_detected || subcarrier_detected);

  wire [7:0] hw_high = {4'h0, timer_underflow};

  // ----------------------------------------------------------------
  // flag and enable next values
  // ----------------------------------------------------------------
  wire [7:0] low_written  = apply_write(event_flags_low, host_wr.flags_low);
  wire [7:0] high_written = apply_write(event_flags_high, host_wr.flags_high);
  // bit 7: set by hardware only, cleared by a clear-all write
  wire       low_clear_all = host_wr.flags_low.wr_en && !host_wr.flags_low.data[irq_ctrl_pkg::MODE_BIT] &&
                             (&host_wr.flags_low.data[6:0]);
  wire [7:0] low_keep     = {event_flags_low[7] && !low_clear_all, low_written[6:0]};
  wire [7:0] flags_low_next  = low_keep | hw_low;
  wire [7:0] enable_low_next  = apply_write(event_enable_low, host_wr.enable_low);
  wire [7:0] enable_high_next = apply_write(event_enable_high, host_wr.enable_high);
  wire       any_pending = |(flags_low_next & enable_low_next) |
                           |(high_written & irq_ctrl_pkg::HIGH_SRC_MASK & enable_high_next) |
                           |(hw_high & enable_high_next);
  wire [7:0] high_src = (high_written | hw_high) & ~(8'h01 << irq_ctrl_pkg::ANY_EVENT_BIT);
  wire [7:0] flags_high_next = high_src | ({7'h00, any_pending} << irq_ctrl_pkg::ANY_EVENT_BIT);
  wire       global_on = flags_high_next[irq_ctrl_pkg::ANY_EVENT_BIT] &&
                         enable_high_next[irq_ctrl_pkg::ANY_EVENT_BIT];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      event_flags_low   <= irq_ctrl_pkg::FLAGS_RST;
      event_flags_high  <= irq_ctrl_pkg::FLAGS_RST;
      event_enable_low  <= irq_ctrl_pkg::ENABLE_RST;
      event_enable_high <= irq_ctrl_pkg::ENABLE_RST;
      idle_prev_reg     <= 1'b1;
      hi_prev_reg       <= 1'b0;
      lo_prev_reg       <= 1'b0;
      tx_prev_reg       <= irq_ctrl_pkg::TX_OTHER;
      status_irq        <= 1'b0;
      irq_out           <= 1'b0;
    end else begin
      event_flags_low   <= flags_low_next;
      event_flags_high  <= flags_high_next;
      event_enable_low  <= enable_low_next;
      event_enable_high <= enable_high_next;
      idle_prev_reg     <= command_is_idle;
      hi_prev_reg       <= fifo_high_status;
      lo_prev_reg       <= fifo_low_status;
      tx_prev_reg       <= tx_state;
      status_irq        <= any_pending;
      irq_out           <= any_pending && irq_pin_enable;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence tx_handoff_s;
    tx_state == irq_ctrl_pkg::TX_PAYLOAD ##1 tx_state == irq_ctrl_pkg::TX_END_FRAME;
  endsequence

  timer_flag_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    timer_underflow[0] |=> event_flags_high[0]) else $error("timer flag not set");
  tx_done_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    tx_handoff_s |=> event_flags_low[irq_ctrl_pkg::TX_DONE_BIT]) else $error("tx flag missed");
  rx_done_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    rx_stream_end |=> event_flags_low[irq_ctrl_pkg::RX_DONE_BIT]) else $error("rx flag missed");
  error_flag_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    (uart_error != 8'h00) |=> event_flags_low[irq_ctrl_pkg::RX_ERROR_BIT]) else $error("error flag missed");
  sof_flag_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    (receiving && sof_detected) |=> event_flags_low[irq_ctrl_pkg::SOF_BIT]) else $error("sof flag missed");
  card_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!card_detect_mode && !event_flags_low[6] && !host_wr.flags_low.wr_en) |=> !event_flags_low[6])
    else $error("card flag without mode");
  flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
    (event_flags_low[1] && !host_wr.flags_low.wr_en) |=> event_flags_low[1]) else $error("flag dropped");
  host_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (host_wr.flags_low.wr_en && host_wr.flags_low.data == 8'h02 && !rx_stream_end) |=> !event_flags_low[1])
    else $error("clear ignored");
  host_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    (host_wr.flags_low.wr_en && host_wr.flags_low.data == 8'h84) |=> event_flags_low[2])
    else $error("set ignored");
  status_track_a: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 status_irq == $past(any_pending)) else $error("status wrong");
  pin_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    irq_out |-> (status_irq && $past(irq_pin_enable))) else $error("pin without enable");
  global_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    |(event_flags_low & event_enable_low) |-> event_flags_high[irq_ctrl_pkg::ANY_EVENT_BIT])
    else $error("global flag missing");

  sequence idle_rise_s;
    !command_is_idle ##1 command_is_idle;
  endsequence

  sequence idle_steady_s;
    command_is_idle ##1 command_is_idle;
  endsequence

  sequence high_rise_s;
    !fifo_high_status ##1 fifo_high_status;
  endsequence

  sequence high_steady_s;
    fifo_high_status ##1 fifo_high_status;
  endsequence

  sequence low_rise_s;
    !fifo_low_status ##1 fifo_low_status;
  endsequence

  // ----------------------------------------------------------------
  // assertions: timer sources
  // ----------------------------------------------------------------
  for (genvar t = 0; t < irq_ctrl_pkg::TIMER_COUNT; t++) begin : g_timer_chk
    timer_each_set_a: assert property (@(posedge clk) disable iff (!rst_b)
      timer_underflow[t]
      |=> event_flags_high[irq_ctrl_pkg::TIMER_BASE_BIT + t])
      else $error("timer flag not set");
  end

  // ----------------------------------------------------------------
  // assertions: edge and level events
  // ----------------------------------------------------------------
  idle_flag_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    idle_rise_s
    |=> event_flags_low[irq_ctrl_pkg::IDLE_BIT])
    else $error("idle flag missed");

  idle_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (idle_steady_s ##0 (!event_flags_low[irq_ctrl_pkg::IDLE_BIT] && !host_wr.flags_low.wr_en))
    |=> !event_flags_low[irq_ctrl_pkg::IDLE_BIT])
    else $error("idle flag repeated");

  fifo_high_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    high_rise_s
    |=> event_flags_low[irq_ctrl_pkg::FIFO_HIGH_BIT])
    else $error("fifo high flag missed");

  fifo_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (high_steady_s ##0 (!event_flags_low[irq_ctrl_pkg::FIFO_HIGH_BIT] && !host_wr.flags_low.wr_en))
    |=> !event_flags_low[irq_ctrl_pkg::FIFO_HIGH_BIT])
    else $error("fifo high flag repeated");

  fifo_low_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    low_rise_s
    |=> event_flags_low[irq_ctrl_pkg::FIFO_LOW_BIT])
    else $error("fifo low flag missed");

  card_flag_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    (card_detected && card_detect_mode)
    |=> event_flags_low[irq_ctrl_pkg::CARD_BIT])
    else $error("card flag missed");

  subcarrier_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    (receiving && subcarrier_detected)
    |=> event_flags_low[irq_ctrl_pkg::SOF_BIT])
    else $error("subcarrier flag missed");

  sof_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!receiving && !event_flags_low[irq_ctrl_pkg::SOF_BIT])
    |=> !event_flags_low[irq_ctrl_pkg::SOF_BIT])
    else $error("sof flag without receive");

  // ----------------------------------------------------------------
  // assertions: host writes
  // ----------------------------------------------------------------
  sof_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (low_clear_all && !hw_low[irq_ctrl_pkg::SOF_BIT])
    |=> !event_flags_low[irq_ctrl_pkg::SOF_BIT])
    else $error("sof flag not cleared");

  set_wins_a: assert property (@(posedge clk) disable iff (!rst_b)
    (rx_stream_end && host_wr.flags_low.wr_en && !host_wr.flags_low.data[irq_ctrl_pkg::MODE_BIT])
    |=> event_flags_low[irq_ctrl_pkg::RX_DONE_BIT])
    else $error("clear beat hardware set");

  high_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    (host_wr.flags_high.wr_en && host_wr.flags_high.data == 8'h81)
    |=> event_flags_high[irq_ctrl_pkg::TIMER_BASE_BIT])
    else $error("timer flag set ignored");

  high_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
    (event_flags_high[irq_ctrl_pkg::TIMER_BASE_BIT] && !host_wr.flags_high.wr_en)
    |=> event_flags_high[irq_ctrl_pkg::TIMER_BASE_BIT])
    else $error("timer flag dropped");

  card_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
    (event_flags_low[irq_ctrl_pkg::CARD_BIT] && !host_wr.flags_low.wr_en)
    |=> event_flags_low[irq_ctrl_pkg::CARD_BIT])
    else $error("card flag dropped");

  timer_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (host_wr.flags_high.wr_en && host_wr.flags_high.data == 8'h7F && timer_underflow == 4'h0)
    |=> event_flags_high[3:0] == 4'h0)
    else $error("timer clear ignored");

  enable_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (host_wr.enable_low.wr_en && host_wr.enable_low.data == 8'h7F)
    |=> event_enable_low == 8'h00)
    else $error("enable clear ignored");

  enable_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    (host_wr.enable_high.wr_en && host_wr.enable_high.data == 8'h8F)
    |=> event_enable_high[3:0] == 4'hF)
    else $error("enable set ignored");

  // ----------------------------------------------------------------
  // assertions: summary outputs
  // ----------------------------------------------------------------
  global_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    !any_pending
    |=> !event_flags_high[irq_ctrl_pkg::ANY_EVENT_BIT])
    else $error("global flag stuck");

  global_on_a: assert property (@(posedge clk) disable iff (!rst_b)
    global_on
    |=> status_irq)
    else $error("status missed global");

  status_global_a: assert property (@(posedge clk) disable iff (!rst_b)
    event_flags_high[irq_ctrl_pkg::ANY_EVENT_BIT]
    |-> status_irq)
    else $error("status behind global");

  status_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    !any_pending
    |=> !status_irq)
    else $error("status stuck");

  pin_track_a: assert property (@(posedge clk) disable iff (!rst_b)
    ##1
    irq_out == ($past(any_pending) && $past(irq_pin_enable)))
    else $error("pin wrong");

  pin_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    !irq_pin_enable
    |=> !irq_out)
    else $error("pin while disabled");
endmodule

// *** tb/host_side_model.sv ***
/*
  Host-side model: register writes and request pin watcher.
  Assumes writes are one-cycle pulses launched just after clk rises.
*/
`timescale 1ns/1ps
module host_side_model (
  // clock
  input  wire logic                  clk,
  // device side
  output irq_ctrl_pkg::host_writes_t host_wr,
  input  wire logic                  irq_out
);
  int   irq_rises;
  logic irq_last;
  initial begin
    host_wr = '0;
    irq_rises = 0;
    irq_last = 1'b0;
  end
  // counts request pin assertions
  always @(posedge clk) begin
    if (irq_out === 1'b1 && irq_last !== 1'b1)
      irq_rises++;
    irq_last <= irq_out;
  end
  // one write pulse, data[7] picks set or clear
  task automatic wr(input int sel, input logic [7:0] d);
    @(posedge clk);
    #1;
    case (sel)
      0: host_wr.flags_low = '{1'b1, d};
      1: host_wr.flags_high = '{1'b1, d};
      2: host_wr.enable_low = '{1'b1, d};
      default: host_wr.enable_high = '{1'b1, d};
    endcase
    @(posedge clk);
    #1;
    host_wr = '0;
  endtask
  // clears handled flags
  task automatic ack();
    wr(0, 8'h7F);
    wr(1, 8'h7F);
  endtask
endmodule

// *** tb/reader_frontend_interrupt_controller_tb.sv ***
/*
  Random and corner stimulus for the interrupt controller.
  Assumes 100 MHz clk and active low asynchronous rst_b.
*/
`timescale 1ns/1ps
module reader_frontend_interrupt_controller_tb;
  logic clk = 1'b0, rst_b = 1'b0, irq_pin_enable = 1'b0, ext = 1'b0, rx_end, cmd_idle, card, sof, subc;
  logic mode = 1'b1, rcv = 1'b1;
  int   rises = 0;
  logic [3:0] tmr;
  logic [7:0] err, fl, fh, el, eh, r, exl, exh;
  logic [9:0] fill;
  logic st, irq;
  irq_ctrl_pkg::host_writes_t host_wr;
  irq_ctrl_pkg::tx_state_t tx;
  int seed = 7, miscompares = 0, samples_checked = 0, k;
  always #5 clk = ~clk;
  irq_ctrl i_irq_ctrl (.clk(clk), .rst_b(rst_b), .host_wr(host_wr), .irq_pin_enable(irq_pin_enable),
    .card_detect_mode(mode), .fifo_threshold(8'h08), .fifo_threshold_extension(ext),
    .timer_underflow(tmr), .tx_state(tx), .rx_stream_end(rx_end), .command_is_idle(cmd_idle),
    .fifo_fill(fill), .uart_error(err), .card_detected(card), .receiving(rcv), .sof_detected(sof),
    .subcarrier_detected(subc), .event_flags_low(fl), .event_flags_high(fh), .event_enable_low(el),
    .event_enable_high(eh), .status_irq(st), .irq_out(irq));
  host_side_model i_host_side_model (.clk(clk), .host_wr(host_wr), .irq_out(irq));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic quiet();
    {rx_end, cmd_idle, card, sof, subc, tmr, err} = '0;
    tx = irq_ctrl_pkg::TX_PAYLOAD;
    fill = 10'h100;
  endtask
  // pulses one event source for one cycle, then waits two cycles so the caller can check the flags
  task automatic fire(input int k);
    @(posedge clk);
    #1;
    case (k)
      0: tx = irq_ctrl_pkg::TX_END_FRAME;
      1: rx_end = 1'b1;
      2: cmd_idle = 1'b1;
      3: fill = 10'h1F8;
      4: fill = 10'h008;
      5: err = 8'h01 << ($random(seed) & 7);
      6: card = 1'b1;
      7: {sof, subc} = ($random(seed) & 1) ? 2'b10 : 2'b01;
      default: tmr[k-8] = 1'b1;
    endcase
    @(posedge clk);
    #1;
    quiet();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
  initial begin
    quiet();
    repeat (6) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk("reset", 8'h00, fl | fh | el | eh | {st, irq});
    for (int it = 0; it < 36; it++) begin
      k = it % 12;
      r = $random(seed);
      irq_pin_enable = $random(seed);
      i_host_side_model.wr(2, 8'h7F);
      i_host_side_model.wr(2, {1'b1, r[6:0]});
      i_host_side_model.wr(3, 8'h7F);
      i_host_side_model.wr(3, {4'h8, r[3:0]});
      chk("enable_low", {1'b0, r[6:0]}, el);
      chk("enable_high", {4'h0, r[3:0]}, eh);
      fire(k);
      exl = (k < 8) ? 8'h01 << k : 8'h00;
      exh = (k < 8) ? 8'h00 : 8'h01 << (k - 8);
      exh[6] = |((exl & {1'b0, r[6:0]}) | (exh & {4'h0, r[3:0]}));
      rises += exh[6] & irq_pin_enable;
      chk("flags_low", exl, fl);
      chk("flags_high", exh, fh);
      chk("status", exh[6], st);
      chk("irq_pin", exh[6] & irq_pin_enable, irq);
      i_host_side_model.ack();
      chk("cleared", 8'h00, fl | fh | {st, irq});
    end
    chk("irq_rises", rises, i_host_side_model.irq_rises);
    i_host_side_model.wr(0, 8'h83);
    i_host_side_model.wr(0, 8'h01);
    chk("host_set", 8'h02, fl);
    fire(7);
    chk("sof_flag", 8'h82, fl);
    i_host_side_model.ack();
    chk("sof_cleared", 8'h00, fl);
    mode = 1'b0;
    rcv = 1'b0;
    fire(6);
    fire(7);
    chk("gated", 8'h00, fl);
    mode = 1'b1;
    rcv = 1'b1;
    ext = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("ext_level", 8'h08, fl);
    end_sim();
  end
endmodule
